//--- core/sser_report.sv
// Contract
// RULE1 - busy with other operations sets access bit 15
// RULE2 - unformatted or unusable medium sets access bit 14
// RULE3 - spare command with no spares left sets access bit 13
// RULE4 - unit not ready sets access bit 12
// RULE5 - write protected unit sets access bit 11
// RULE6 - read of never-written block sets access bit 10
// RULE7 - unrecoverable error bit 6, second one bit 7, first address kept
// RULE8 - end-of-file sets access bit 4, parameter holds following block address
// RULE9 - past end of volume sets access bit 3, parameter holds last block
// RULE10 - release for operator load or unload sets info bit 15
// RULE11 - host may deny release, else grants it while idle
// RULE12 - diagnostic release sets info bit 14, maintenance release bit 13
// RULE13 - exactly one spare left sets info bit 12
// RULE14 - host too slow without data loss sets info bit 11
// RULE15 - automatic sparing without loss sets info bit 8
// RULE16 - several recoverable errors set info bit 6, first one kept
// RULE17 - difficult recovery sets info bit 5, plain recovery bit 4
// RULE18 - full maintenance track sets info bit 2
// RULE19 - parameter area holds parameters of the most serious error
// RULE20 - spare operation: start address in 3 words, byte length in 2
// RULE21 - cross-unit: byte list of units ended by FF hex
// RULE22 - diagnostic: failed numbers one byte each in first 3 words
//
// Local design decisions: the register addresses and strobed register access.
module sser_report #(
   parameter int UNITS = 10 // room in the cross-unit list, marker included
) (
   input wire logic clk_sys, // system clock, 125 MHz
   input wire logic sys_rst, // synchronous reset, active high
   input wire sser_pkg::sser_evt_s evt, // condition pulses from drive logic
   input wire sser_pkg::sser_arg_s arg, // payload beside the pulses
   input wire logic [sser_pkg::ADDR_W-1:0] reg_addr, // register word index
   input wire logic [sser_pkg::FIELD_W-1:0] reg_wdata, // write data
   input wire logic reg_wr, // write strobe
   input wire logic reg_rd, // read strobe
   output logic [sser_pkg::FIELD_W-1:0] reg_rdata, // read data, cycle after strobe
   output logic [sser_pkg::FIELD_W-1:0] access_field, // live access-errors field
   output logic [sser_pkg::FIELD_W-1:0] info_field, // live information field
   output logic release_req // any release request pending
);
   localparam int PW = sser_pkg::PAR_WORDS * sser_pkg::FIELD_W;

   logic [sser_pkg::FIELD_W-1:0] next_access;
   logic [sser_pkg::FIELD_W-1:0] next_info;
   logic [PW-1:0] par;
   logic [3:0] sev;
   logic [3:0] sev_base;
   sser_pkg::sser_pkind_e pkind;
   logic unrec_seen;
   logic rec_seen;
   logic hold;
   logic clr;
   logic [UNITS*8-1:0] unit_bytes;
   logic [sser_pkg::DIAG_WORDS*16-1:0] diag_bytes;
   logic [2:0] diag_cnt;

   // ==========================================
   // software clear pulse; hold freezes the report while host reads it
   assign clr = reg_wr && reg_addr == sser_pkg::REG_CTRL && reg_wdata[sser_pkg::CTRL_CLEAR];

   always_ff @(posedge clk_sys) begin
      if (sys_rst)
         hold <= 1'b0;
      else if (reg_wr && reg_addr == sser_pkg::REG_CTRL)
         hold <= reg_wdata[sser_pkg::CTRL_HOLD];
   end

   // ==========================================
   // access-errors field; new events win over a clear in the same cycle
   always_comb begin
      next_access = clr ? sser_pkg::FIELD_RST : access_field;
      if (!hold) begin
         if (evt.parallel_busy) next_access[sser_pkg::AE_PARALLEL] = 1'b1; // [RULE1]
         if (evt.media_unusable) next_access[sser_pkg::AE_UNINIT] = 1'b1; // [RULE2]
         if (evt.no_spares) next_access[sser_pkg::AE_NO_SPARES] = 1'b1; // [RULE3]
         if (evt.not_ready) next_access[sser_pkg::AE_NOT_READY] = 1'b1; // [RULE4]
         if (evt.write_prot) next_access[sser_pkg::AE_WPROT] = 1'b1; // [RULE5]
         if (evt.no_data) next_access[sser_pkg::AE_NO_DATA] = 1'b1; // [RULE6]
         if (evt.unrec_err) begin
            next_access[sser_pkg::AE_UNREC] = 1'b1; // [RULE7]
            if (unrec_seen && !clr)
               next_access[sser_pkg::AE_UNREC_OVF] = 1'b1; // [RULE7]
         end
         if (evt.eof_mark) next_access[sser_pkg::AE_EOF] = 1'b1; // [RULE8]
         if (evt.end_volume) next_access[sser_pkg::AE_EOV] = 1'b1; // [RULE9]
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst)
         access_field <= sser_pkg::FIELD_RST;
      else
         access_field <= next_access;
   end

   // ==========================================
   // information field
   always_comb begin
      next_info = clr ? sser_pkg::FIELD_RST : info_field;
      if (!hold) begin
         if (evt.rel_oper) next_info[sser_pkg::IN_REL_OPER] = 1'b1; // [RULE10]
         if (evt.rel_diag) next_info[sser_pkg::IN_REL_DIAG] = 1'b1; // [RULE12]
         if (evt.rel_maint) next_info[sser_pkg::IN_REL_MAINT] = 1'b1; // [RULE12]
         if (evt.one_spare) next_info[sser_pkg::IN_ONE_SPARE] = 1'b1; // [RULE13]
         if (evt.overrun) next_info[sser_pkg::IN_OVERRUN] = 1'b1; // [RULE14]
         if (evt.auto_spare) next_info[sser_pkg::IN_AUTO_SPARE] = 1'b1; // [RULE15]
         if (evt.rec_err && rec_seen && !clr)
            next_info[sser_pkg::IN_REC_OVF] = 1'b1; // [RULE16]
         if (evt.marginal) next_info[sser_pkg::IN_MARGINAL] = 1'b1; // [RULE17]
         if (evt.rec_err) next_info[sser_pkg::IN_REC] = 1'b1; // [RULE17]
         if (evt.mt_full) next_info[sser_pkg::IN_MT_OVF] = 1'b1; // [RULE18]
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst)
         info_field <= sser_pkg::FIELD_RST;
      else
         info_field <= next_info;
   end

   // release line only reports; granting is the host's decision
   always_ff @(posedge clk_sys) begin
      if (sys_rst)
         release_req <= 1'b0;
      else
         release_req <= |next_info[sser_pkg::IN_REL_OPER:sser_pkg::IN_REL_MAINT]; // [RULE11]
   end

   // ==========================================
   // first-error trackers for the overflow bits
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         unrec_seen <= 1'b0;
         rec_seen <= 1'b0;
      end else begin
         if (evt.unrec_err && !hold)
            unrec_seen <= 1'b1;
         else if (clr)
            unrec_seen <= 1'b0;
         if (evt.rec_err && !hold)
            rec_seen <= 1'b1;
         else if (clr)
            rec_seen <= 1'b0;
      end
   end

   // ==========================================
   // cross-unit list and diagnostic byte packing
   sser_bytelist #(
      .DEPTH(UNITS)
   ) u_units (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .clear(clr),
      .push(evt.xunit_err && !hold),
      .din(arg.unit),
      .terminate(evt.xunit_err && !hold),
      .bytes(unit_bytes)
   );

   always_ff @(posedge clk_sys) begin
      if (sys_rst || (clr && !(evt.diag_fail && !hold))) begin
         diag_bytes <= '0;
         diag_cnt <= '0;
      end else if (clr) begin
         // a result in the clear cycle opens the new list
         diag_bytes <= {arg.diag_num, {($bits(diag_bytes)-8){1'b0}}}; // [RULE22]
         diag_cnt <= 3'h1;
      end else if (evt.diag_fail && !hold && int'(diag_cnt) < 2 * sser_pkg::DIAG_WORDS) begin
         diag_bytes[(2*sser_pkg::DIAG_WORDS-1-int'(diag_cnt))*8 +: 8] <= arg.diag_num; // [RULE22]
         diag_cnt <= diag_cnt + 3'h1;
      end
   end

   // ==========================================
   // parameter area: the most serious event owns it; equal rank keeps the first except special kinds, where the latest wins,
   // so overflow cases still report the first error's address
   assign sev_base = clr ? sser_pkg::SEV_NONE : sev;

   // a clear drops the old owner; an event in the same cycle still takes over
   always_ff @(posedge clk_sys) begin
      if (sys_rst || clr) begin
         par <= '0;
         sev <= sser_pkg::SEV_NONE;
         pkind <= sser_pkg::SSER_PK_NONE;
      end
      if (!sys_rst && !hold) begin
         if (evt.spare_done) begin
            par <= {arg.addr, arg.length}; // [RULE20]
            sev <= sser_pkg::SEV_SPECIAL;
            pkind <= sser_pkg::SSER_PK_SPARE;
         end else if (evt.xunit_err) begin
            pkind <= sser_pkg::SSER_PK_XUNIT; // [RULE21]
            sev <= sser_pkg::SEV_SPECIAL;
         end else if (evt.diag_fail) begin
            pkind <= sser_pkg::SSER_PK_DIAG; // [RULE22]
            sev <= sser_pkg::SEV_SPECIAL;
         end else if (evt.unrec_err && sev_base < sser_pkg::SEV_UNREC) begin
            par <= {arg.addr, 32'h0000_0000}; // [RULE7]
            sev <= sser_pkg::SEV_UNREC; // [RULE19]
            pkind <= sser_pkg::SSER_PK_ADDR;
         end else if (evt.end_volume && sev_base < sser_pkg::SEV_EOV) begin
            par <= {arg.addr, 32'h0000_0000}; // [RULE9]
            sev <= sser_pkg::SEV_EOV;
            pkind <= sser_pkg::SSER_PK_ADDR;
         end else if (evt.eof_mark && sev_base < sser_pkg::SEV_EOF) begin
            par <= {arg.addr, 32'h0000_0000}; // [RULE8]
            sev <= sser_pkg::SEV_EOF;
            pkind <= sser_pkg::SSER_PK_ADDR;
         end else if (evt.marginal && sev_base < sser_pkg::SEV_MARG) begin
            par <= {arg.addr, 32'h0000_0000}; // [RULE19]
            sev <= sser_pkg::SEV_MARG;
            pkind <= sser_pkg::SSER_PK_ADDR;
         end else if (evt.rec_err && sev_base < sser_pkg::SEV_REC) begin
            par <= {arg.addr, 32'h0000_0000}; // [RULE16]
            sev <= sser_pkg::SEV_REC;
            pkind <= sser_pkg::SSER_PK_ADDR;
         end
      end
   end

   // ==========================================
   // parameter word view chosen by kind
   logic [PW-1:0] par_view;
   always_comb begin
      case (pkind)
         sser_pkg::SSER_PK_XUNIT: par_view = unit_bytes[UNITS*8-1 -: PW];
         sser_pkg::SSER_PK_DIAG: par_view = {diag_bytes, 32'h0000_0000};
         default: par_view = par;
      endcase
   end

   // ==========================================
   // read port; unmapped words read zero
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         if (reg_addr == sser_pkg::REG_ACCESS)
            reg_rdata <= access_field;
         else if (reg_addr == sser_pkg::REG_INFO)
            reg_rdata <= info_field;
         else if (reg_addr >= sser_pkg::REG_PAR0 && reg_addr <= sser_pkg::REG_PAR4)
            reg_rdata <= par_view[PW-1-16*int'(reg_addr - sser_pkg::REG_PAR0) -: 16];
         else if (reg_addr == sser_pkg::REG_KIND)
            reg_rdata <= {13'h0000, pkind};
         else if (reg_addr == sser_pkg::REG_CTRL)
            reg_rdata <= {14'h0000, hold, 1'b0};
         else
            reg_rdata <= '0;
      end else begin
         reg_rdata <= '0;
      end
   end
endmodule

//--- common/sser_pkg.sv
package sser_pkg;
   // ==========================================
   // field widths
   localparam int FIELD_W = 16;
   localparam int ADDR_W = 4;
   localparam int PAR_WORDS = 5;
   localparam int UNIT_LIST_MAX = 10;

   // ==========================================
   // access-errors bit positions
   localparam int AE_PARALLEL = 15;
   localparam int AE_UNINIT = 14;
   localparam int AE_NO_SPARES = 13;
   localparam int AE_NOT_READY = 12;
   localparam int AE_WPROT = 11;
   localparam int AE_NO_DATA = 10;
   localparam int AE_UNREC_OVF = 7;
   localparam int AE_UNREC = 6;
   localparam int AE_EOF = 4;
   localparam int AE_EOV = 3;

   // ==========================================
   // information field bit positions
   localparam int IN_REL_OPER = 15;
   localparam int IN_REL_DIAG = 14;
   localparam int IN_REL_MAINT = 13;
   localparam int IN_ONE_SPARE = 12;
   localparam int IN_OVERRUN = 11;
   localparam int IN_AUTO_SPARE = 8;
   localparam int IN_REC_OVF = 6;
   localparam int IN_MARGINAL = 5;
   localparam int IN_REC = 4;
   localparam int IN_MT_OVF = 2;

   // ==========================================
   // parameter area constants
   localparam logic [7:0] UNIT_LIST_END = 8'hFF;
   localparam logic [15:0] FIELD_RST = 16'h0000;
   localparam int SPARE_ADDR_WORDS = 3;
   localparam int SPARE_LEN_WORDS = 2;
   localparam int DIAG_WORDS = 3;

   // ==========================================
   // register map, word indices on the plain register port
   localparam logic [ADDR_W-1:0] REG_ACCESS = 4'h0;
   localparam logic [ADDR_W-1:0] REG_INFO = 4'h1;
   localparam logic [ADDR_W-1:0] REG_PAR0 = 4'h2;
   localparam logic [ADDR_W-1:0] REG_PAR4 = 4'h6;
   localparam logic [ADDR_W-1:0] REG_KIND = 4'h7;
   localparam logic [ADDR_W-1:0] REG_CTRL = 4'h8;
   localparam int CTRL_CLEAR = 0;
   localparam int CTRL_HOLD = 1;

   // which content the parameter area carries
   typedef enum logic [2:0] {
      SSER_PK_NONE = 3'h0,
      SSER_PK_ADDR = 3'h1,
      SSER_PK_SPARE = 3'h2,
      SSER_PK_XUNIT = 3'h3,
      SSER_PK_DIAG = 3'h4
   } sser_pkind_e;

   // severity ranks; larger is more serious
   localparam logic [3:0] SEV_NONE = 4'h0;
   localparam logic [3:0] SEV_REC = 4'h1;
   localparam logic [3:0] SEV_MARG = 4'h2;
   localparam logic [3:0] SEV_EOF = 4'h3;
   localparam logic [3:0] SEV_EOV = 4'h4;
   localparam logic [3:0] SEV_UNREC = 4'h5;
   localparam logic [3:0] SEV_SPECIAL = 4'h6;

   // condition events from the drive logic, one-cycle pulses
   typedef struct packed {
      logic parallel_busy;
      logic media_unusable;
      logic no_spares;
      logic not_ready;
      logic write_prot;
      logic no_data;
      logic unrec_err;
      logic eof_mark;
      logic end_volume;
      logic rel_oper;
      logic rel_diag;
      logic rel_maint;
      logic one_spare;
      logic overrun;
      logic auto_spare;
      logic marginal;
      logic rec_err;
      logic mt_full;
      logic spare_done;
      logic xunit_err;
      logic diag_fail;
   } sser_evt_s;

   // addresses and payloads that ride with the events
   typedef struct packed {
      logic [47:0] addr;
      logic [31:0] length;
      logic [7:0] unit;
      logic [7:0] diag_num;
   } sser_arg_s;
endpackage

//--- core/sser_bytelist.sv
// ==========================================
// byte list: appends bytes, packs two per word, high byte first
module sser_bytelist #(
   parameter int DEPTH = 10
) (
   input wire logic clk_sys, // system clock
   input wire logic sys_rst, // synchronous reset
   input wire logic clear, // empty the list
   input wire logic push, // append one byte
   input wire logic [7:0] din, // byte to append
   input wire logic terminate, // close the list with the end marker
   output logic [DEPTH*8-1:0] bytes // list, byte 0 in the top lane
);
   localparam int CW = $clog2(DEPTH + 1);
   logic [CW-1:0] count;
   logic [CW-1:0] last;

   assign last = CW'(DEPTH - 1);

   // ==========================================
   // storage; the last slot is kept for the end marker
   always_ff @(posedge clk_sys) begin
      if (sys_rst || (clear && !push)) begin
         bytes <= '1;
         count <= '0;
      end else if (clear) begin
         // a push in the clear cycle starts the new list rather than being lost
         bytes <= {din, {(DEPTH-1){8'hFF}}};
         count <= CW'(1);
      end else if (push && count < last) begin
         bytes[(DEPTH-1-int'(count))*8 +: 8] <= din;
         count <= count + CW'(1);
      end else if (terminate) begin
         bytes[(DEPTH-1-int'(count))*8 +: 8] <= sser_pkg::UNIT_LIST_END; // [RULE21]
      end
   end
endmodule

//--- bench/sser_report_monitor.sv
// ==========================================
// checker on the report block ports
module sser_report_checker (
   input wire logic clk_sys, // clock
   input wire logic sys_rst, // reset
   input wire sser_pkg::sser_evt_s evt, // event pulses
   input wire sser_pkg::sser_arg_s arg, // event payload
   input wire logic [sser_pkg::ADDR_W-1:0] reg_addr, // word index
   input wire logic [sser_pkg::FIELD_W-1:0] reg_wdata, // write data
   input wire logic reg_wr, // write strobe
   input wire logic reg_rd, // read strobe
   input wire logic [sser_pkg::FIELD_W-1:0] reg_rdata, // read data
   input wire logic [sser_pkg::FIELD_W-1:0] access_field, // access errors
   input wire logic [sser_pkg::FIELD_W-1:0] info_field, // information
   input wire logic release_req // release pending
);
   timeunit 1ns;
   timeprecision 1ps;
   logic hold;
   logic clr;
   assign clr = reg_wr && reg_addr == sser_pkg::REG_CTRL && reg_wdata[sser_pkg::CTRL_CLEAR];
   // mirror of the hold bit, events are dropped while it is set
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         hold <= 1'b0;
      end else if (reg_wr && reg_addr == sser_pkg::REG_CTRL) begin
         hold <= reg_wdata[sser_pkg::CTRL_HOLD];
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   property p_busy; evt.parallel_busy && !hold |=> access_field[15]; endproperty
   a_busy: assert property (p_busy) else $error("busy bit missing");
   property p_wprot; evt.write_prot && !hold |=> access_field[11]; endproperty
   a_wprot: assert property (p_wprot) else $error("protect bit missing");
   property p_ovf;
      evt.unrec_err && !hold && !clr && access_field[6] |=> access_field[7] && access_field[6];
   endproperty
   a_ovf: assert property (p_ovf) else $error("overflow bit missing");
   // a sticky bit only drops through a clear write or a reset
   property p_eof_stick; $fell(access_field[4]) |-> $past(clr) || $past(sys_rst); endproperty
   a_eof_stick: assert property (p_eof_stick) else $error("eof bit lost");
   property p_eov; evt.end_volume && !hold |=> access_field[3]; endproperty
   a_eov: assert property (p_eov) else $error("volume bit missing");
   property p_oper; evt.rel_oper && !hold |=> info_field[15] ##1 release_req; endproperty
   a_oper: assert property (p_oper) else $error("operator release missing");
   property p_diag; evt.rel_diag && !hold |=> info_field[14] ##1 release_req; endproperty
   a_diag: assert property (p_diag) else $error("diag release missing");
   property p_ovr; evt.overrun && !hold |=> info_field[11]; endproperty
   a_ovr: assert property (p_ovr) else $error("overrun bit missing");
   property p_rec; evt.rec_err && !hold |=> info_field[4]; endproperty
   a_rec: assert property (p_rec) else $error("recovered bit missing");
   property p_mt; evt.mt_full && !hold |=> info_field[2]; endproperty
   a_mt: assert property (p_mt) else $error("log full bit missing");
   c_eof: cover property (evt.eof_mark ##1 access_field[4]);
   c_rel: cover property ($rose(release_req));
   c_ovf: cover property ($rose(access_field[7]));
endmodule

bind sser_report sser_report_checker chk (
   .clk_sys(clk_sys), .sys_rst(sys_rst), .evt(evt), .arg(arg), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .access_field(access_field), .info_field(info_field), .release_req(release_req)
);

//--- bench/sser_host_model.sv
// ==========================================
// host channel: register master and release grant
module sser_host_model (
   input wire logic clk_sys, // clock
   input wire logic release_req, // release pending
   input wire logic idle, // host has no other work
   input wire logic [15:0] reg_rdata, // read data
   output logic [sser_pkg::ADDR_W-1:0] reg_addr, // word index
   output logic [15:0] reg_wdata, // write data
   output logic reg_wr, // write strobe
   output logic reg_rd // read strobe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic granting;
   initial begin
      reg_addr = '0;
      reg_wdata = '0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      granting = 1'b0;
   end
   // released lines show the inverse so stale values are not trusted
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      #1;
      d = reg_rdata;
   endtask
   // grant only while idle; a busy host leaves the request pending
   always @(posedge clk_sys) begin
      if (granting) begin
         reg_wr <= 1'b0;
         reg_addr <= ~sser_pkg::REG_CTRL;
         reg_wdata <= 16'hFFFE;
         granting <= 1'b0;
      end else if (idle && release_req) begin
         reg_addr <= sser_pkg::REG_CTRL;
         reg_wdata <= 16'h0001;
         reg_wr <= 1'b1;
         granting <= 1'b1;
      end
   end
endmodule

//--- bench/tb_storage_status_error_report.sv
module tb_storage_status_error_report;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys;
   logic sys_rst;
   sser_pkg::sser_evt_s evt;
   sser_pkg::sser_arg_s arg;
   logic [3:0] reg_addr;
   logic [15:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [15:0] reg_rdata;
   logic [15:0] access_field;
   logic [15:0] info_field;
   logic release_req;
   logic idle;
   int err_count;
   int samples_checked;
   logic [15:0] exp_bit [18] = '{16'h8000, 16'h4000, 16'h2000, 16'h1000, 16'h0800, 16'h0400,
      16'h0040, 16'h0010, 16'h0008, 16'h8000, 16'h4000, 16'h2000, 16'h1000, 16'h0800,
      16'h0100, 16'h0020, 16'h0010, 16'h0004};
   sser_report dut (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .evt(evt), .arg(arg), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .access_field(access_field), .info_field(info_field), .release_req(release_req)
   );
   sser_host_model host (
      .clk_sys(clk_sys), .release_req(release_req), .idle(idle), .reg_rdata(reg_rdata),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd)
   );
   // ==========================================
   // helpers
   function automatic sser_pkg::sser_evt_s mk(input int i);
      return sser_pkg::sser_evt_s'(21'h1 << (20 - i)); // index in struct order
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask
   task automatic rdchk(input logic [3:0] a, input logic [15:0] exp);
      logic [15:0] d;
      host.rd(a, d);
      chk(d, exp, "register read");
   endtask
   task automatic par3(input logic [47:0] a);
      rdchk(sser_pkg::REG_PAR0, a[47:32]);
      rdchk(sser_pkg::REG_PAR0 + 4'h1, a[31:16]);
      rdchk(sser_pkg::REG_PAR0 + 4'h2, a[15:0]);
   endtask
   task automatic fire(input sser_pkg::sser_evt_s e, input sser_pkg::sser_arg_s a);
      @(posedge clk_sys);
      evt <= e;
      arg <= a;
      @(posedge clk_sys);
      evt <= '0;
      #1;
   endtask
   task automatic do_reset;
      @(posedge clk_sys);
      sys_rst <= 1'b1;
      repeat (5) @(posedge clk_sys);
      sys_rst <= 1'b0;
   endtask
   // ==========================================
   // scenarios
   task automatic t_bits;
      for (int i = 0; i < 18; i++) begin
         fire(mk(i), '0);
         chk(access_field, i < 9 ? exp_bit[i] : 16'h0000, "access");
         chk(info_field, i < 9 ? 16'h0000 : exp_bit[i], "info");
         @(posedge clk_sys);
         #1;
         chk({15'h0000, release_req}, {15'h0000, i >= 9 && i <= 11}, "release");
         host.wr(sser_pkg::REG_CTRL, 16'h0001);
      end
      for (int a = 0; a < 16; a++) begin
         rdchk(4'(a), 16'h0000);
      end
      $display("test bits done");
   endtask
   task automatic t_par;
      do_reset;
      fire(mk(6), {48'h0A01_0011_0022, 48'h0});
      fire(mk(6), {48'h0B02_0033_0044, 48'h0});
      chk(access_field, 16'h00C0, "unrec overflow");
      par3(48'h0A01_0011_0022);
      do_reset;
      fire(mk(16), {48'h0C03_0001_0002, 48'h0});
      fire(mk(16), {48'h0D04_0003_0004, 48'h0});
      chk(info_field, 16'h0050, "rec overflow");
      par3(48'h0C03_0001_0002);
      fire(mk(7), {48'h0E05_0005_0006, 48'h0});
      par3(48'h0E05_0005_0006);
      fire(mk(8), {48'h0F06_0007_0008, 48'h0});
      par3(48'h0F06_0007_0008);
      fire(mk(7), {48'h0107_0009_000A, 48'h0});
      par3(48'h0F06_0007_0008);
      rdchk(sser_pkg::REG_KIND, 16'h0001);
      $display("test severity done");
   endtask
   task automatic t_special;
      do_reset;
      fire(mk(18), {48'h0001_0002_0003, 32'h0004_0005, 16'h0});
      par3(48'h0001_0002_0003);
      rdchk(sser_pkg::REG_PAR0 + 4'h3, 16'h0004);
      rdchk(sser_pkg::REG_PAR4, 16'h0005);
      rdchk(sser_pkg::REG_KIND, 16'h0002);
      do_reset;
      fire(mk(19), {80'h0, 8'h03, 8'h00});
      fire(mk(19), {80'h0, 8'h05, 8'h00});
      fire(mk(19), {80'h0, 8'h00, 8'h00});
      rdchk(sser_pkg::REG_PAR0, 16'h0305);
      rdchk(sser_pkg::REG_PAR0 + 4'h1, 16'h00FF);
      rdchk(sser_pkg::REG_KIND, 16'h0003);
      fire(mk(20), {88'h0, 8'h11});
      fire(mk(20), {88'h0, 8'h22});
      rdchk(sser_pkg::REG_PAR0, 16'h1122);
      rdchk(sser_pkg::REG_PAR4, 16'h0000);
      rdchk(sser_pkg::REG_KIND, 16'h0004);
      $display("test special done");
   endtask
   task automatic t_ctrl;
      host.wr(sser_pkg::REG_CTRL, 16'h0002);
      rdchk(sser_pkg::REG_CTRL, 16'h0002);
      fire(mk(7), '0);
      chk(access_field, 16'h0000, "held event");
      host.wr(sser_pkg::REG_CTRL, 16'h0001);
      fire(mk(8), {48'h0A0A_0B0B_0C0C, 48'h0});
      fork
         fire(mk(7), {48'h0102_0304_0506, 48'h0});
         host.wr(sser_pkg::REG_CTRL, 16'h0001);
      join
      chk(access_field, 16'h0010, "set beats clear");
      par3(48'h0102_0304_0506);
      $display("test control done");
   endtask
   task automatic t_grant;
      int n;
      do_reset;
      fire(mk(11), '0);
      idle <= 1'b1;
      n = 0;
      while (info_field !== 16'h0000 && n < 20) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      idle <= 1'b0;
      chk(info_field, 16'h0000, "release granted");
      repeat (4) @(posedge clk_sys);
      $display("test grant done");
   endtask
   task automatic close_out;
      $display("checked %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // ==========================================
   // clock, sequence and watchdog
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   initial begin
      sys_rst = 1'b1;
      evt = '0;
      arg = '0;
      idle = 1'b0;
      err_count = 0;
      samples_checked = 0;
      do_reset;
      t_bits;
      t_par;
      t_special;
      t_ctrl;
      t_grant;
      close_out;
   end
   // the whole run needs about 270 cycles, the limit allows 20000 cycles
   initial begin
      #160000;
      err_count++;
      close_out;
   end
endmodule
